// ### hw/twt_target.sv
// two-wire bus target engine with apb register access
// assumes scl and sda come from pins outside the clock domain
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/100ps
module twt_target (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_out,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out
);
    twt_pkg::twt_pins_t sy1_reg, sy2_reg, sy3_reg;
    twt_pkg::twt_ctl_t ctl_reg;
    twt_pkg::twt_state_t state_reg, st_next;
    logic done_reg, wc_reg, str_reg, str_next, drv_reg, drv_next;
    logic rw_reg, rw_next, gc_reg, gc_next, al_reg, al_next;
    logic rxa_reg, rxa_next, last_reg, last_next, mack_reg, mack_next;
    logic spend_reg, done_set, dat_cap;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] sh_reg, sh_next, own_reg, data_reg, code_reg, code_next;
    logic [5:0] shold_reg;
    logic [31:0] prdata_reg, rd_mux;

    // bus access decode
    wire acc = psel_in && penable_in && ce_in;
    wire setup = psel_in && !penable_in && ce_in;
    wire hit_ctrl = paddr_in == twt_pkg::OFF_CTRL;
    wire hit_cond = paddr_in == twt_pkg::OFF_COND;
    wire hit_own = paddr_in == twt_pkg::OFF_OWN;
    wire hit_data = paddr_in == twt_pkg::OFF_DATA;
    wire hit = hit_ctrl || hit_cond || hit_own || hit_data;
    wire wr = acc && pwrite_in;
    wire wr_ctrl = wr && hit_ctrl;
    wire wr_data = wr && hit_data;
    wire clr_done = wr_ctrl && pwdata_in[twt_pkg::B_DONE];
    assign pready_out = ce_in;
    assign pslverr_out = acc && !hit;
    assign prdata_out = prdata_reg;

    // bus line conditions, all from synchronised samples
    wire scl_s = sy2_reg.scl;
    wire sda_s = sy2_reg.sda;
    wire scl_rise = scl_s && !sy3_reg.scl;
    wire scl_fall = !scl_s && sy3_reg.scl;
    wire start_det = scl_s && sy3_reg.scl && !sda_s && sy3_reg.sda;
    wire stop_det = scl_s && sy3_reg.scl && sda_s && !sy3_reg.sda;
    wire addressed = state_reg == twt_pkg::S_RX || state_reg == twt_pkg::S_RACK
        || state_reg == twt_pkg::S_TX || state_reg == twt_pkg::S_TACK;
    wire bus_free = state_reg == twt_pkg::S_IDLE && scl_s && sda_s;
    wire own_hit = ctl_reg.ack_en && sh_reg[7:1] == own_reg[7:1];
    // general call only with own-address lsb
    wire gc_hit = ctl_reg.ack_en && own_reg[0] && sh_reg[7:1] == twt_pkg::GC_ADDR;
    wire cont_rx = code_reg == twt_pkg::C_SLAW || code_reg == twt_pkg::C_ALW
        || code_reg == twt_pkg::C_GC || code_reg == twt_pkg::C_ALGC
        || code_reg == twt_pkg::C_RX || code_reg == twt_pkg::C_GRX;
    wire cont_tx = code_reg == twt_pkg::C_SLAR || code_reg == twt_pkg::C_ALR
        || code_reg == twt_pkg::C_TX;
    wire exit_code = !cont_rx && !cont_tx;
    wire wait_clr = state_reg == twt_pkg::S_WAIT && clr_done;
    wire [7:0] aack_code = rw_reg ? (al_reg ? twt_pkg::C_ALR : twt_pkg::C_SLAR)
        : gc_reg ? (al_reg ? twt_pkg::C_ALGC : twt_pkg::C_GC)
        : (al_reg ? twt_pkg::C_ALW : twt_pkg::C_SLAW);
    wire [7:0] rack_code = gc_reg ? (rxa_reg ? twt_pkg::C_GRX : twt_pkg::C_GRXN)
        : (rxa_reg ? twt_pkg::C_RX : twt_pkg::C_RXN);
    // last byte ends in 0xc0 or 0xc8
    wire [7:0] tack_code = last_reg ? (mack_reg ? twt_pkg::C_TXL : twt_pkg::C_TXN)
        : (mack_reg ? twt_pkg::C_TX : twt_pkg::C_TXN);

    // stretch scl while done in wait state
    assign scl_oe_out = done_reg && str_reg;
    assign scl_out = 1'b0;
    assign sda_oe_out = drv_reg || shold_reg != 6'h00;
    assign sda_out = 1'b0;

    always_comb begin
        rd_mux = 32'h0;
        if (hit_ctrl) begin
            rd_mux[7:0] = {done_reg, ctl_reg.ack_en, ctl_reg.sta, ctl_reg.sto,
                wc_reg, ctl_reg.en, 1'b0, ctl_reg.ie};
        end else if (hit_cond) begin
            rd_mux[7:0] = {code_reg[7:3], 3'h0};
        end else if (hit_own) begin
            rd_mux[7:0] = own_reg;
        end else if (hit_data) begin
            rd_mux[7:0] = data_reg;
        end
    end

    always_comb begin
        st_next = state_reg;
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        drv_next = drv_reg;
        code_next = code_reg;
        str_next = str_reg;
        rw_next = rw_reg;
        gc_next = gc_reg;
        al_next = al_reg || shold_reg == 6'h01;
        rxa_next = rxa_reg;
        last_next = last_reg;
        mack_next = mack_reg;
        done_set = 1'b0;
        dat_cap = 1'b0;
        if (!ctl_reg.en) begin
            st_next = twt_pkg::S_IDLE;
            drv_next = 1'b0;
        end else if (start_det || stop_det) begin
            st_next = start_det ? twt_pkg::S_ADDR : twt_pkg::S_IDLE;
            cnt_next = 4'h0;
            drv_next = 1'b0;
            if (addressed) begin
                done_set = 1'b1;
                code_next = twt_pkg::C_STOP;
                str_next = 1'b0;
            end
        end else if (wait_clr) begin
            cnt_next = 4'h0;
            if (cont_rx) begin
                st_next = twt_pkg::S_RX;
                // ack choice travels with the clearing write
                rxa_next = pwdata_in[twt_pkg::B_ACK];
            end else if (cont_tx) begin
                st_next = twt_pkg::S_TX;
                last_next = !pwdata_in[twt_pkg::B_ACK];
                drv_next = !data_reg[7];
                sh_next = {data_reg[6:0], 1'b0};
            end else begin
                st_next = twt_pkg::S_IGN;
            end
        end else begin
            case (state_reg)
                twt_pkg::S_ADDR, twt_pkg::S_RX: begin
                    if (scl_rise) begin
                        sh_next = {sh_reg[6:0], sda_s};
                        cnt_next = cnt_reg + 4'h1;
                    end
                    if (scl_fall && cnt_reg == 4'h8 && state_reg == twt_pkg::S_RX) begin
                        dat_cap = 1'b1;
                        drv_next = rxa_reg;
                        st_next = twt_pkg::S_RACK;
                    end else if (scl_fall && cnt_reg == 4'h8) begin
                        rw_next = sh_reg[0];
                        gc_next = !own_hit;
                        drv_next = own_hit || gc_hit;
                        st_next = (own_hit || gc_hit) ? twt_pkg::S_AACK : twt_pkg::S_IGN;
                    end
                end
                twt_pkg::S_AACK: begin
                    if (scl_fall) begin
                        drv_next = 1'b0;
                        done_set = 1'b1;
                        str_next = 1'b1;
                        code_next = aack_code;
                        al_next = 1'b0;
                        st_next = twt_pkg::S_WAIT;
                    end
                end
                twt_pkg::S_RACK: begin
                    if (scl_fall) begin
                        drv_next = 1'b0;
                        done_set = 1'b1;
                        str_next = 1'b1;
                        code_next = rack_code;
                        st_next = twt_pkg::S_WAIT;
                    end
                end
                twt_pkg::S_TX: begin
                    if (scl_rise) begin
                        cnt_next = cnt_reg + 4'h1;
                    end
                    if (scl_fall && cnt_reg == 4'h8) begin
                        drv_next = 1'b0;
                        st_next = twt_pkg::S_TACK;
                    end else if (scl_fall) begin
                        drv_next = !sh_reg[7];
                        sh_next = {sh_reg[6:0], 1'b0};
                    end
                end
                twt_pkg::S_TACK: begin
                    if (scl_rise) begin
                        mack_next = !sda_s;
                    end
                    if (scl_fall) begin
                        done_set = 1'b1;
                        str_next = 1'b1;
                        code_next = tack_code;
                        st_next = twt_pkg::S_WAIT;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sy1_reg <= 2'h3;
            sy2_reg <= 2'h3;
            sy3_reg <= 2'h3;
        end else if (ce_in) begin
            sy1_reg <= {scl_in, sda_in};
            sy2_reg <= sy1_reg;
            sy3_reg <= sy2_reg;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_reg <= twt_pkg::S_IDLE;
            cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
            drv_reg <= 1'b0;
            code_reg <= twt_pkg::C_NONE;
            str_reg <= 1'b0;
            {rw_reg, gc_reg, al_reg, rxa_reg, last_reg, mack_reg} <= 6'h00;
        end else if (ce_in) begin
            state_reg <= st_next;
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            drv_reg <= drv_next;
            code_reg <= code_next;
            str_reg <= str_next;
            {rw_reg, gc_reg, al_reg} <= {rw_next, gc_next, al_next};
            {rxa_reg, last_reg, mack_reg} <= {rxa_next, last_next, mack_next};
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctl_reg <= 5'h00;
            done_reg <= 1'b0;
            wc_reg <= 1'b0;
            own_reg <= twt_pkg::OWN_RST;
            data_reg <= twt_pkg::DATA_RST;
            prdata_reg <= 32'h0;
        end else if (ce_in) begin
            if (wr_ctrl) begin
                ctl_reg <= {pwdata_in[twt_pkg::B_ACK], pwdata_in[twt_pkg::B_STA],
                    pwdata_in[twt_pkg::B_STO], pwdata_in[twt_pkg::B_EN],
                    pwdata_in[twt_pkg::B_IE]};
            end
            // set wins over a same-cycle clear
            done_reg <= done_set || (done_reg && !clr_done);
            if (wr_data) begin
                wc_reg <= !done_reg;
            end
            if (wr && hit_own) begin
                own_reg <= pwdata_in[7:0];
            end
            if (dat_cap) begin
                data_reg <= sh_reg;
            end else if (wr_data && done_reg) begin
                data_reg <= pwdata_in[7:0];
            end
            if (setup) begin
                prdata_reg <= rd_mux;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            spend_reg <= 1'b0;
            shold_reg <= 6'h00;
        end else if (ce_in) begin
            // start once the bus is free
            if (wait_clr && exit_code && pwdata_in[twt_pkg::B_STA]) begin
                spend_reg <= 1'b1;
            end else if (clr_done && state_reg != twt_pkg::S_WAIT
                && pwdata_in[twt_pkg::B_STA]) begin
                spend_reg <= 1'b1;
            end else if (shold_reg == 6'h01) begin
                spend_reg <= 1'b0;
            end
            if (spend_reg && bus_free && shold_reg == 6'h00) begin
                shold_reg <= twt_pkg::START_HOLD_CYC;
            end else if (shold_reg != 6'h00) begin
                shold_reg <= shold_reg - 6'h01;
            end
        end
    end

    default clocking dcb @(posedge sys_clk_in);
    endclocking
    default disable iff (!nrst_in || !ce_in);

    sequence s_clear_at(logic [7:0] c);
        state_reg == twt_pkg::S_WAIT && code_reg == c && clr_done;
    endsequence
    sequence s_addr_done;
        state_reg == twt_pkg::S_ADDR && scl_fall && cnt_reg == 4'h8;
    endsequence

    chk_stretch_hold: assert property (done_reg && state_reg == twt_pkg::S_WAIT
        |-> scl_oe_out)
        else $error("scl not held while done");
    chk_gc_next: assert property (s_clear_at(twt_pkg::C_GRX)
        and (ctl_reg.en && !start_det && !stop_det)
        |=> state_reg == twt_pkg::S_RX && rxa_reg == $past(pwdata_in[twt_pkg::B_ACK]))
        else $error("general call byte not continued");
    chk_gc_exit: assert property (s_clear_at(twt_pkg::C_GRXN)
        and (ctl_reg.en && !start_det && !stop_det)
        |=> state_reg == twt_pkg::S_IGN)
        else $error("0x98 clear did not leave addressed state");
    chk_stop_code: assert property (addressed && stop_det && ctl_reg.en
        |=> done_reg && code_reg == twt_pkg::C_STOP && !scl_oe_out)
        else $error("stop while addressed not reported");
    chk_own_match: assert property (s_addr_done and (ctl_reg.en && !start_det && !stop_det
        && own_hit) |=> state_reg == twt_pkg::S_AACK && sda_oe_out)
        else $error("own address not acknowledged");
    chk_gc_ignore: assert property (s_addr_done and (ctl_reg.en && !start_det && !stop_det
        && !own_hit && !own_reg[0]) |=> state_reg == twt_pkg::S_IGN)
        else $error("general call taken while disabled");
    chk_noack_isolate: assert property (s_addr_done and (ctl_reg.en && !ctl_reg.ack_en
        && !start_det && !stop_det) |=> state_reg == twt_pkg::S_IGN)
        else $error("address recognised without ack enable");
    chk_addr_code: assert property (state_reg == twt_pkg::S_AACK && scl_fall && ctl_reg.en
        && !start_det && !stop_det |=> done_reg ##0 (rw_reg ? code_reg[7:4] >= 4'ha
        : code_reg[7:4] <= 4'h7))
        else $error("wrong mode code after address");
    chk_last_code: assert property (state_reg == twt_pkg::S_TACK && last_reg && scl_fall
        && ctl_reg.en && !start_det && !stop_det
        |=> code_reg == twt_pkg::C_TXN || code_reg == twt_pkg::C_TXL)
        else $error("last byte code wrong");
    chk_ign_release: assert property (state_reg == twt_pkg::S_IGN && shold_reg == 6'h00
        |-> !sda_oe_out)
        else $error("sda driven while not addressed");
    chk_start_hold: assert property ($rose(shold_reg != 6'h00) |-> sda_oe_out [*8])
        else $error("start not held");
endmodule : twt_target

// ### include/twt_pkg.sv
// constants, types and register map of the two-wire target block
// assumes a 10 MHz system clock and an apb master with 32-bit data
package twt_pkg;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_COND = 8'h04;
    localparam logic [7:0] OFF_OWN = 8'h08;
    localparam logic [7:0] OFF_DATA = 8'h0c;
    localparam int B_DONE = 7;
    localparam int B_ACK = 6;
    localparam int B_STA = 5;
    localparam int B_STO = 4;
    localparam int B_WC = 3;
    localparam int B_EN = 2;
    localparam int B_IE = 0;
    localparam logic [7:0] OWN_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'hff;
    localparam logic [6:0] GC_ADDR = 7'h00;
    localparam logic [7:0] C_NONE = 8'hf8;
    localparam logic [7:0] C_SLAW = 8'h60;
    localparam logic [7:0] C_ALW = 8'h68;
    localparam logic [7:0] C_GC = 8'h70;
    localparam logic [7:0] C_ALGC = 8'h78;
    localparam logic [7:0] C_RX = 8'h80;
    localparam logic [7:0] C_RXN = 8'h88;
    localparam logic [7:0] C_GRX = 8'h90;
    localparam logic [7:0] C_GRXN = 8'h98;
    localparam logic [7:0] C_STOP = 8'ha0;
    localparam logic [7:0] C_SLAR = 8'ha8;
    localparam logic [7:0] C_ALR = 8'hb0;
    localparam logic [7:0] C_TX = 8'hb8;
    localparam logic [7:0] C_TXN = 8'hc0;
    localparam logic [7:0] C_TXL = 8'hc8;
    localparam int CLK_PERIOD_NS = 100;
    localparam int START_HOLD_NS = 4000;
    localparam logic [5:0] START_HOLD_CYC =
        6'((START_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_ADDR = 4'h1,
        S_AACK = 4'h2,
        S_RX = 4'h3,
        S_RACK = 4'h4,
        S_TX = 4'h5,
        S_TACK = 4'h6,
        S_WAIT = 4'h7,
        S_IGN = 4'h8
    } twt_state_t;
    typedef struct packed {
        logic ack_en;
        logic sta;
        logic sto;
        logic en;
        logic ie;
    } twt_ctl_t;
    typedef struct packed {
        logic scl;
        logic sda;
    } twt_pins_t;
endpackage : twt_pkg

// ### dv/twt_bus_master.sv
// two-wire bus master model for the far side of the target
// assumes pull-ups resolve both lines outside this module
`timescale 1ns/100ps
module twt_bus_master (
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_low_out,
    output logic sda_low_out
);
    initial begin
        scl_low_out = 1'b0;
        sda_low_out = 1'b0;
    end
    // release scl, then wait while the target stretches it
    task automatic scl_up(input int hold_ns);
        scl_low_out = 1'b0;
        wait (scl_in === 1'b1);
        #hold_ns;
    endtask : scl_up
    task automatic start_cond();
        #37;
        sda_low_out = 1'b0;
        #363;
        scl_up(437);
        sda_low_out = 1'b1;
        #400;
        scl_low_out = 1'b1;
    endtask : start_cond
    task automatic stop_cond();
        #37;
        sda_low_out = 1'b1;
        #400;
        scl_up(437);
        sda_low_out = 1'b0;
        #400;
    endtask : stop_cond
    task automatic clock_bit(input logic val, output logic seen);
        #137;
        sda_low_out = ~val;
        #263;
        scl_up(237);
        seen = sda_in;
        #200;
        scl_low_out = 1'b1;
    endtask : clock_bit
    task automatic send_byte(input logic [7:0] val, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(val[i], s);
        end
        clock_bit(1'b1, s);
        acked = ~s;
    endtask : send_byte
    task automatic take_byte(input logic ack, output logic [7:0] val);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, s);
            val[i] = s;
        end
        clock_bit(~ack, s);
    endtask : take_byte
endmodule : twt_bus_master

// ### dv/tb_top.sv
// self-checking bench for the two-wire target engine
// assumes the bus master model and pull-ups on both lines
`timescale 1ns/100ps
module tb_top;
    logic sys_clk_in, nrst_in, psel_in, penable_in, pwrite_in;
    logic [7:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, r;
    logic pready_out, pslverr_out, scl_out, scl_oe_out, sda_out, sda_oe_out;
    logic m_scl_low, m_sda_low, ack, err, ce_in;
    logic [7:0] b;
    twt_pkg::twt_pins_t line;
    int errors = 0;
    int comparisons = 0;
    assign line.scl = ~(m_scl_low | scl_oe_out);
    assign line.sda = ~(m_sda_low | sda_oe_out);
    twt_target twt_target_inst (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .ce_in(ce_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .scl_in(line.scl),
        .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_in(line.sda),
        .sda_out(sda_out), .sda_oe_out(sda_oe_out));
    twt_bus_master twt_bus_master_inst (.scl_in(line.scl), .sda_in(line.sda),
        .scl_low_out(m_scl_low), .sda_low_out(m_sda_low));
    initial begin
        sys_clk_in = 1'b0;
        forever #50 sys_clk_in = ~sys_clk_in;
    end
    task automatic conclude();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge sys_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= addr;
        pwdata_in <= wd;
        @(posedge sys_clk_in);
        penable_in <= 1'b1;
        @(posedge sys_clk_in);
        while (pready_out !== 1'b1) @(posedge sys_clk_in);
        r = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb
    // poll the done flag, then read the masked condition code
    task automatic expect_state(input logic done, input logic [7:0] code);
        apb(1'b0, twt_pkg::OFF_CTRL, 32'h0);
        for (int n = 0; n < 12 && r[twt_pkg::B_DONE] !== 1'b1; n++) begin
            apb(1'b0, twt_pkg::OFF_CTRL, 32'h0);
        end
        check("done flag", {31'h0, done}, {31'h0, r[twt_pkg::B_DONE]});
        if (done) begin
            apb(1'b0, twt_pkg::OFF_COND, 32'h0);
            check("condition code", {24'h0, code}, r & 32'h0000_00f8);
        end
    endtask : expect_state
    task automatic clear(input logic ack_en, input logic sta);
        apb(1'b1, twt_pkg::OFF_CTRL, {24'h0, 1'b1, ack_en, sta, 5'h04});
    endtask : clear
    task automatic addr_byte(input logic [7:0] val, input logic exp_ack);
        twt_bus_master_inst.start_cond();
        twt_bus_master_inst.send_byte(val, ack);
        check("address ack", {31'h0, exp_ack}, {31'h0, ack});
    endtask : addr_byte
    task automatic t_regs();
        apb(1'b0, twt_pkg::OFF_CTRL, 32'h0);
        check("ctrl reset", 32'h0, r);
        apb(1'b0, twt_pkg::OFF_COND, 32'h0);
        check("code reset", {24'h0, twt_pkg::C_NONE}, r);
        apb(1'b0, twt_pkg::OFF_DATA, 32'h0);
        check("data reset", {24'h0, twt_pkg::DATA_RST}, r);
        apb(1'b1, twt_pkg::OFF_DATA, 32'h12);
        apb(1'b0, twt_pkg::OFF_CTRL, 32'h0);
        check("collision flag", 32'h8, r);
        apb(1'b0, twt_pkg::OFF_DATA, 32'h0);
        check("data kept", {24'h0, twt_pkg::DATA_RST}, r);
        check("pin levels", 32'h0, {30'h0, scl_out, sda_out});
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        apb(1'b1, twt_pkg::OFF_OWN, 32'h55);
        apb(1'b0, twt_pkg::OFF_OWN, 32'h0);
        check("own readback", 32'h55, r);
        ce_in <= 1'b0;
        fork
            apb(1'b1, twt_pkg::OFF_OWN, 32'h12);
            begin
                repeat (4) @(negedge sys_clk_in);
                check("ready while frozen", 32'h0, {31'h0, pready_out});
                @(posedge sys_clk_in);
                ce_in <= 1'b1;
            end
        join
        apb(1'b0, twt_pkg::OFF_OWN, 32'h0);
        check("write after freeze", 32'h12, r);
        apb(1'b1, twt_pkg::OFF_OWN, 32'h55);
        apb(1'b1, twt_pkg::OFF_CTRL, 32'h44);
    endtask : t_regs
    task automatic rx_data(input logic [7:0] val, input logic exp_ack, input logic [7:0] code);
        twt_bus_master_inst.send_byte(val, ack);
        check("data ack", {31'h0, exp_ack}, {31'h0, ack});
        expect_state(1'b1, code);
        apb(1'b0, twt_pkg::OFF_DATA, 32'h0);
        check("received byte", {24'h0, val}, r);
    endtask : rx_data
    task automatic t_rx();
        addr_byte(8'h54, 1'b1);
        expect_state(1'b1, twt_pkg::C_SLAW);
        clear(1'b1, 1'b0);
        rx_data(8'ha5, 1'b1, twt_pkg::C_RX);
        clear(1'b0, 1'b0);
        rx_data(8'h3c, 1'b0, twt_pkg::C_RXN);
        clear(1'b1, 1'b0);
        addr_byte(8'h00, 1'b1);
        expect_state(1'b1, twt_pkg::C_GC);
        clear(1'b1, 1'b0);
        rx_data(8'h11, 1'b1, twt_pkg::C_GRX);
        clear(1'b0, 1'b0);
        rx_data(8'h22, 1'b0, twt_pkg::C_GRXN);
        clear(1'b0, 1'b0);
        addr_byte(8'h54, 1'b0);
        expect_state(1'b0, 8'h00);
        twt_bus_master_inst.stop_cond();
        apb(1'b1, twt_pkg::OFF_CTRL, 32'h44);
        addr_byte(8'h54, 1'b1);
        expect_state(1'b1, twt_pkg::C_SLAW);
        clear(1'b1, 1'b0);
        twt_bus_master_inst.stop_cond();
        expect_state(1'b1, twt_pkg::C_STOP);
        clear(1'b1, 1'b0);
        apb(1'b1, twt_pkg::OFF_OWN, 32'h54);
        addr_byte(8'h00, 1'b0);
        twt_bus_master_inst.stop_cond();
        apb(1'b1, twt_pkg::OFF_OWN, 32'h55);
    endtask : t_rx
    task automatic tx_data(input logic [7:0] val, input logic ack_en, input logic m_ack);
        apb(1'b1, twt_pkg::OFF_DATA, {24'h0, val});
        clear(ack_en, 1'b0);
        twt_bus_master_inst.take_byte(m_ack, b);
        check("sent byte", {24'h0, val}, {24'h0, b});
    endtask : tx_data
    task automatic t_tx();
        addr_byte(8'h55, 1'b1);
        expect_state(1'b1, twt_pkg::C_SLAR);
        tx_data(8'hc3, 1'b1, 1'b1);
        expect_state(1'b1, twt_pkg::C_TX);
        tx_data(8'h5a, 1'b0, 1'b1);
        expect_state(1'b1, twt_pkg::C_TXL);
        clear(1'b1, 1'b0);
        twt_bus_master_inst.take_byte(1'b0, b);
        check("released line", 32'hff, {24'h0, b});
        twt_bus_master_inst.stop_cond();
        addr_byte(8'h55, 1'b1);
        expect_state(1'b1, twt_pkg::C_SLAR);
        tx_data(8'h77, 1'b0, 1'b0);
        expect_state(1'b1, twt_pkg::C_TXN);
        clear(1'b1, 1'b1);
        twt_bus_master_inst.stop_cond();
        for (int n = 0; n < 200 && sda_oe_out !== 1'b1; n++) @(negedge sys_clk_in);
        check("start issued", 32'h1, {31'h0, sda_oe_out});
        for (int n = 0; n < 200 && sda_oe_out !== 1'b0; n++) @(negedge sys_clk_in);
        apb(1'b1, twt_pkg::OFF_CTRL, 32'h44);
        addr_byte(8'h55, 1'b1);
        expect_state(1'b1, twt_pkg::C_ALR);
        tx_data(8'h0f, 1'b0, 1'b0);
        expect_state(1'b1, twt_pkg::C_TXN);
        clear(1'b1, 1'b0);
        twt_bus_master_inst.stop_cond();
    endtask : t_tx
    initial begin
        nrst_in = 1'b0;
        ce_in = 1'b1;
        psel_in = 1'b0;
        penable_in = 1'b0;
        pwrite_in = 1'b0;
        paddr_in = 8'h00;
        pwdata_in = 32'h0;
        repeat (6) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        t_regs();
        t_rx();
        t_tx();
        conclude();
    end
    initial begin
        repeat (40000) @(posedge sys_clk_in);
        errors++;
        conclude();
    end
endmodule : tb_top
